// [mis_pkg.sv]
// Constants, register map and types for the monitor serial slave port.
package mis_pkg;

  // Internal register addresses reached through the 32-bit serial command.
  localparam logic [9:0]  REG_ADDR_MEAS   = 10'h038;
  localparam logic [9:0]  REG_ADDR_OVR    = 10'h043;
  localparam logic [9:0]  REG_ADDR_RAW    = 10'h070;
  localparam logic [15:0] MEAS_RESET      = 16'h0000;
  localparam logic [15:0] OVR_RESET       = 16'h0000;
  localparam int          OVR_EN_BIT      = 15;
  localparam int          OVR_ADDR_LSB    = 0;
  localparam int          MEAS_CODE_LSB   = 12;
  localparam int          ADDR_PM_BIT     = 2;

  // Layout of the 32-bit internal register command word.
  localparam int          CMD_DATA_LSB    = 0;
  localparam int          CMD_ADDR_LSB    = 16;
  localparam int          CMD_OP_LSB      = 26;
  localparam logic [3:0]  OP_READ         = 4'h1;
  localparam logic [3:0]  OP_WRITE        = 4'h2;
  localparam logic [2:0]  CMD_LAST_BYTE   = 3'h3;

  // PMBus command codes and fixed values.
  localparam logic [7:0]  PM_PAGE         = 8'h00;
  localparam logic [7:0]  PM_CLEAR_FAULT  = 8'h03;
  localparam logic [7:0]  PM_VOUT_MODE    = 8'h20;
  localparam logic [7:0]  PM_READ_VOUT    = 8'h8B;
  localparam logic [7:0]  PM_READ_TEMP    = 8'h8D;
  localparam logic [7:0]  PM_RAW_SUPPLY   = 8'hD4;
  localparam logic [7:0]  PAGE_ALL        = 8'hFF;
  localparam logic [7:0]  PAGE_RESET      = 8'h01;
  localparam logic [7:0]  VOUT_MODE_BYTE  = 8'h12;
  localparam logic [7:0]  TX_IDLE_BYTE    = 8'hFF;
  localparam int          L11_MANT_W      = 11;
  localparam int          L11_EXP_W       = 5;

  // Slave address per measurement code, I2C form, first monitor site.
  localparam logic [6:0]  ADDR_LUT [16] = '{
    7'h32, 7'h0B, 7'h13, 7'h1B, 7'h23, 7'h2B, 7'h33, 7'h3B,
    7'h43, 7'h4B, 7'h53, 7'h5B, 7'h63, 7'h6B, 7'h73, 7'h3A
  };

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_RX     = 3'b011,
    ST_TX     = 3'b100,
    ST_MACK   = 3'b101,
    ST_IGNORE = 3'b110
  } mis_state_t;

  typedef enum logic [1:0] {
    MD_NONE = 2'b00,
    MD_I2C  = 2'b01,
    MD_PM   = 2'b10
  } mis_mode_t;

endpackage : mis_pkg

// [mis_slave.sv]
// Serial I2C and PMBus slave port of the on-chip monitor.
`timescale 1ns/10ps

module mis_slave
  import mis_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        cfg_done,
  input  wire logic        adc_eoc,
  input  wire logic [15:0] adc_data,
  input  wire logic [15:0] supply_code,
  input  wire logic [10:0] temp_mant,
  input  wire logic [4:0]  temp_exp,
  output logic [5:0]       sense_chan,
  output logic             fault_clear,
  output logic             fault_clear_all
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        scl_meta;
  logic        scl_s;
  logic        scl_d;
  logic        sda_meta;
  logic        sda_s;
  logic        sda_d;
  mis_state_t  state;
  mis_state_t  next_state;
  mis_mode_t   mode;
  mis_mode_t   next_mode;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic        next_oe_n;
  logic        ack_ph;
  logic        next_ack_ph;
  logic        rd;
  logic        next_rd;
  logic        m_acked;
  logic        next_m_acked;
  logic [2:0]  bidx;
  logic [2:0]  next_bidx;
  logic [15:0] meas;
  logic        meas_taken;
  logic [15:0] ovr;
  logic [31:0] cmd;
  logic [15:0] drp_rdata;
  logic [7:0]  pm_cmd;
  logic [7:0]  page;
  logic [15:0] rsp;

  // Reset is released through two flops so every flop leaves reset together.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Both bus lines come from outside and pass two flops before any use.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= sda_i;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  wire       ovr_active = ovr[OVR_EN_BIT] & cfg_done;
  wire [3:0] meas_code  = meas[MEAS_CODE_LSB +: 4];
  wire [6:0] lut_addr   = ADDR_LUT[meas_code];
  wire [6:0] base_addr  = ovr_active ? ovr[OVR_ADDR_LSB +: 7] : lut_addr;
  wire [6:0] i2c_addr   = {base_addr[6:3], 1'b0, base_addr[1:0]};
  wire [6:0] pm_addr    = {base_addr[6:3], 1'b1, base_addr[1:0]};

  wire [7:0] rx_byte   = {sh[6:0], sda_s};
  wire       last_bit  = scl_rise & (cnt == 4'h7);
  wire       addr_done = (state == ST_ADDR) & last_bit & ~stop_det & ~start_det;
  wire       addr_rd   = addr_done & sda_s;
  wire       hit_i2c   = (sh[6:0] == i2c_addr);
  wire       hit_pm    = (sh[6:0] == pm_addr);
  wire       rx_done   = (state == ST_RX) & last_bit & ~stop_det & ~start_det;
  wire [2:0] bidx_inc  = (bidx == 3'h7) ? bidx : bidx + 3'h1;

  wire [31:0] cmd_word  = {rx_byte, cmd[23:0]};
  wire [3:0]  cmd_op    = cmd_word[CMD_OP_LSB +: 4];
  wire [9:0]  cmd_addr  = cmd_word[CMD_ADDR_LSB +: 10];
  wire [15:0] cmd_data  = cmd_word[CMD_DATA_LSB +: 16];
  wire        i2c_rx    = rx_done & (mode == MD_I2C);
  wire        cmd_exec  = i2c_rx & (bidx == CMD_LAST_BYTE);
  wire        ovr_wr    = cmd_exec & (cmd_op == OP_WRITE) & (cmd_addr == REG_ADDR_OVR);
  wire        drp_rd_en = cmd_exec & (cmd_op == OP_READ);
  wire [15:0] drp_rd    = (cmd_addr == REG_ADDR_MEAS) ? meas :
                          (cmd_addr == REG_ADDR_OVR)  ? ovr :
                          (cmd_addr == REG_ADDR_RAW)  ? supply_code : 16'h0000;

  wire        pm_rx     = rx_done & (mode == MD_PM);
  wire        pm_cmd_wr = pm_rx & (bidx == 3'h0);
  wire        page_wr   = pm_rx & (bidx == 3'h1) & (pm_cmd == PM_PAGE);
  wire        clr_hit   = pm_cmd_wr & (rx_byte == PM_CLEAR_FAULT);

  wire page_valid = (page == 8'h01) | (page == 8'h02) | (page == 8'h06) |
                    ((page >= 8'h0D) & (page <= 8'h0F)) |
                    ((page >= 8'h20) & (page <= 8'h23));
  wire [5:0]  page_chan = page_valid ? page[5:0] : 6'h00;

  // raw code times three quarters gives the 2^-14 scale
  wire [17:0] vout_prod = {2'b00, supply_code} * 18'h0_0003;
  wire [15:0] vout_l16  = vout_prod[17:2];
  wire [15:0] temp_l11  = {temp_exp[L11_EXP_W-1:0], temp_mant[L11_MANT_W-1:0]};
  wire [15:0] pm_resp   = (pm_cmd == PM_PAGE)       ? {8'h00, page} :
                          (pm_cmd == PM_VOUT_MODE)  ? {8'h00, VOUT_MODE_BYTE} :
                          (pm_cmd == PM_READ_VOUT)  ? vout_l16 :
                          (pm_cmd == PM_READ_TEMP)  ? temp_l11 :
                          (pm_cmd == PM_RAW_SUPPLY) ? supply_code : 16'h0000;

  wire [7:0]  tx_byte   = (bidx == 3'h0) ? rsp[7:0] :
                          (bidx == 3'h1) ? rsp[15:8] : TX_IDLE_BYTE;

  always_comb begin
    next_state   = state;
    next_mode    = mode;
    next_cnt     = cnt;
    next_sh      = sh;
    next_oe_n    = sda_oe_n;
    next_ack_ph  = ack_ph;
    next_rd      = rd;
    next_m_acked = m_acked;
    next_bidx    = bidx;
    if (stop_det) begin
      next_state  = ST_IDLE;
      next_oe_n   = 1'b1;
      next_ack_ph = 1'b0;
    end else if (start_det) begin
      // A repeated start reopens address phase but keeps the command bytes.
      next_state  = ST_ADDR;
      next_cnt    = 4'h0;
      next_oe_n   = 1'b1;
      next_ack_ph = 1'b0;
      next_bidx   = 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_oe_n = 1'b1;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_sh  = rx_byte;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_cnt = 4'h0;
              next_rd  = sda_s;
              if (hit_i2c) begin
                next_mode  = MD_I2C;
                next_state = ST_ACK;
              end else if (hit_pm) begin
                next_mode  = MD_PM;
                next_state = ST_ACK;
              end else begin
                next_mode  = MD_NONE;
                next_state = ST_IGNORE;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_ph) begin
              next_oe_n   = 1'b0;
              next_ack_ph = 1'b1;
            end else begin
              next_ack_ph = 1'b0;
              next_cnt    = 4'h0;
              if (rd) begin
                next_sh    = {tx_byte[6:0], 1'b0};
                next_oe_n  = tx_byte[7];
                next_state = ST_TX;
              end else begin
                next_oe_n  = 1'b1;
                next_state = ST_RX;
              end
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_sh  = rx_byte;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_cnt   = 4'h0;
              next_bidx  = bidx_inc;
              next_state = ST_ACK;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_oe_n  = 1'b1;
              next_cnt   = 4'h0;
              next_state = ST_MACK;
            end else begin
              next_oe_n = sh[7];
              next_sh   = {sh[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_m_acked = ~sda_s;
            if (!sda_s) begin
              next_bidx = bidx_inc;
            end
          end else if (scl_fall) begin
            if (m_acked) begin
              next_sh    = {tx_byte[6:0], 1'b0};
              next_oe_n  = tx_byte[7];
              next_cnt   = 4'h0;
              next_state = ST_TX;
            end else begin
              next_state = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          next_oe_n = 1'b1;
        end
        default: begin
          next_state = ST_IDLE;
          next_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      mode     <= MD_NONE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      sda_oe_n <= 1'b1;
      ack_ph   <= 1'b0;
      rd       <= 1'b0;
      m_acked  <= 1'b0;
      bidx     <= 3'h0;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      cnt      <= next_cnt;
      sh       <= next_sh;
      sda_oe_n <= next_oe_n;
      ack_ph   <= next_ack_ph;
      rd       <= next_rd;
      m_acked  <= next_m_acked;
      bidx     <= next_bidx;
    end
  end

  // The line is only ever pulled low; a high level is left to the pull-up.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meas       <= MEAS_RESET;
      meas_taken <= 1'b0;
    end else if (cfg_done & adc_eoc & ~meas_taken) begin
      meas       <= adc_data;
      meas_taken <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovr <= OVR_RESET;
    end else if (ovr_wr) begin
      ovr <= cmd_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= 32'h0000_0000;
    end else if (i2c_rx & ~bidx[2]) begin
      cmd[{bidx[1:0], 3'b000} +: 8] <= rx_byte;
    end
  end

  // read data latched at command end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drp_rdata <= 16'h0000;
    end else if (drp_rd_en) begin
      drp_rdata <= drp_rd;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_cmd <= 8'h00;
      page   <= PAGE_RESET;
    end else begin
      if (pm_cmd_wr) begin
        pm_cmd <= rx_byte;
      end
      if (page_wr) begin
        page <= rx_byte;
      end
    end
  end

  // The reply is frozen at the read address so it cannot tear mid-word.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= 16'h0000;
    end else if (addr_rd & hit_pm) begin
      rsp <= pm_resp;
    end else if (addr_rd & hit_i2c) begin
      rsp <= drp_rdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sense_chan <= 6'h00;
    end else begin
      sense_chan <= page_chan;
    end
  end

  // fault clear, all supplies on page FFh
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_clear     <= 1'b0;
      fault_clear_all <= 1'b0;
    end else begin
      fault_clear     <= clr_hit;
      fault_clear_all <= clr_hit & (page == PAGE_ALL);
    end
  end

endmodule : mis_slave

// [mis_slave_sva.sv]
// Assertion checker for the monitor serial slave port.
`timescale 1ns/10ps
module mis_slave_sva (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        cfg_done,
  input wire logic        adc_eoc,
  input wire logic [15:0] adc_data,
  input wire logic [15:0] supply_code,
  input wire logic [10:0] temp_mant,
  input wire logic [4:0]  temp_exp,
  input wire logic [5:0]  sense_chan,
  input wire logic        fault_clear,
  input wire logic        fault_clear_all
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Longest legal pull is an address acknowledge followed by a zero byte.
  logic [7:0] low_run;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) low_run <= 8'h00;
    else if (sda_oe_n) low_run <= 8'h00;
    else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
  end
  sequence s_one_pulse;
    fault_clear ##1 !fault_clear;
  endsequence
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data output not low");
  a_fault_one_cycle: assert property ($rose(fault_clear) |-> s_one_pulse)
    else $error("fault clear not one cycle");
  a_fault_all_pair: assert property (fault_clear_all |-> fault_clear)
    else $error("fault clear all alone");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
    else $error("data pin changed with clock high");
  a_chan_legal: assert property (sense_chan inside {6'h00, 6'h01, 6'h02, 6'h06,
    [6'h0D:6'h0F], [6'h20:6'h23]})
    else $error("illegal channel");
  a_chan_reset: assert property ($rose(nrst) |-> ##[1:4] sense_chan == 6'h01)
    else $error("page not at first supply");
  a_quiet_reset: assert property ($rose(nrst) |-> (sda_oe_n && !fault_clear) [*3])
    else $error("activity right after reset");
  a_pull_bounded: assert property (low_run <= 8'h50)
    else $error("data pin held low too long");
endmodule : mis_slave_sva

bind mis_slave mis_slave_sva u_mis_slave_sva (.mclk(mclk), .nrst(nrst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg_done(cfg_done),
  .adc_eoc(adc_eoc), .adc_data(adc_data), .supply_code(supply_code),
  .temp_mant(temp_mant), .temp_exp(temp_exp), .sense_chan(sense_chan),
  .fault_clear(fault_clear), .fault_clear_all(fault_clear_all));

// [mis_master.sv]
// Bus master model that drives the serial link of the slave port.
`timescale 1ns/10ps
module mis_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // The bus clock stands high between frames.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w
  task bit_io(input logic b, output logic r);
    pull = !b;
    w(4);
    scl = 1'b1;
    w(2);
    r = sda;
    w(2);
    scl = 1'b0;
  endtask : bit_io
  task start();
    pull = 1'b0;
    w(4);
    scl = 1'b1;
    w(2);
    pull = 1'b1;
    w(4);
    scl = 1'b0;
  endtask : start
  task stop();
    pull = 1'b1;
    // A full low half period lets the slave drop its acknowledge before the clock rises.
    w(4);
    scl = 1'b1;
    w(2);
    pull = 1'b0;
    w(4);
  endtask : stop
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rbyte
endmodule : mis_master

// [tb_monitor_i2c_pmbus_slave_access.sv]
// Self-checking bench for the monitor serial slave port.
`timescale 1ns/10ps
module tb_monitor_i2c_pmbus_slave_access;
  import mis_pkg::*;
  logic        mclk, nrst, cfg_done, adc_eoc, sda_o, sda_oe_n, fault_clear;
  logic        fault_clear_all, scl, pull, sda, fc_seen, fa_seen, ack;
  logic [15:0] adc_data, supply_code, rd;
  logic [10:0] temp_mant;
  logic [4:0]  temp_exp;
  logic [5:0]  sense_chan;
  int          errors, check_count, cycles;
  // The wire has a pull-up; either party only pulls it low.
  assign sda = !(pull || !sda_oe_n);
  mis_slave u_mis_slave (.mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .cfg_done(cfg_done), .adc_eoc(adc_eoc), .adc_data(adc_data),
    .supply_code(supply_code), .temp_mant(temp_mant), .temp_exp(temp_exp),
    .sense_chan(sense_chan), .fault_clear(fault_clear), .fault_clear_all(fault_clear_all));
  mis_master u_mis_master (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (fault_clear === 1'b1) fc_seen <= 1'b1;
    if (fault_clear_all === 1'b1) fa_seen <= 1'b1;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
  end
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task do_reset();
    nrst = 1'b0;
    cfg_done = 1'b0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (10) @(negedge mclk);
  endtask : do_reset
  task pulse(input logic [15:0] v);
    @(negedge mclk);
    adc_data = v;
    adc_eoc = 1'b1;
    @(negedge mclk);
    adc_eoc = 1'b0;
  endtask : pulse
  task probe(input logic [6:0] a, input logic exp, input string what);
    u_mis_master.start();
    u_mis_master.wbyte({a, 1'b0}, ack);
    u_mis_master.stop();
    check({15'h0000, ack}, {15'h0000, exp}, what);
  endtask : probe
  task xfer(input logic [6:0] a, input logic [31:0] c, input int n, input logic rdp);
    logic ok;
    ok = 1'b1;
    rd = 16'h0000;
    u_mis_master.start();
    u_mis_master.wbyte({a, 1'b0}, ok);
    for (int i = 0; i < n; i++) begin
      u_mis_master.wbyte(c[8*i +: 8], ack);
      ok &= ack;
    end
    if (rdp) begin
      u_mis_master.start();
      u_mis_master.wbyte({a, 1'b1}, ack);
      ok &= ack;
      u_mis_master.rbyte(1'b0, rd[7:0]);
      u_mis_master.rbyte(1'b1, rd[15:8]);
    end
    u_mis_master.stop();
    check({15'h0000, ok}, 16'h0001, "acknowledge");
  endtask : xfer
  task t_reset();
    do_reset();
    check({15'h0000, sda_oe_n}, 16'h0001, "idle pin");
    check({15'h0000, sda_o}, 16'h0000, "data out level");
    check({10'h000, sense_chan}, 16'h0001, "reset page");
    xfer(7'h32, {2'b00, OP_READ, REG_ADDR_MEAS, 16'h0000}, 4, 1'b1);
    check(rd, MEAS_RESET, "measurement reset");
    xfer(7'h32, {2'b00, OP_READ, REG_ADDR_OVR, 16'h0000}, 4, 1'b1);
    check(rd, OVR_RESET, "override reset");
    $display("test reset done");
  endtask : t_reset
  task t_codes();
    logic [6:0] tbl [9] = '{7'h32, 7'h0B, 7'h13, 7'h1B, 7'h23, 7'h2B, 7'h33, 7'h3B, 7'h43};
    for (int c = 0; c < 9; c++) begin
      do_reset();
      cfg_done = 1'b1;
      pulse({c[3:0], 12'h000});
      pulse(16'hF000);
      probe(tbl[c], 1'b1, "i2c address");
      probe(tbl[c] | 7'h04, 1'b1, "pmbus address");
      probe(tbl[c] ^ 7'h10, 1'b0, "foreign address");
    end
    xfer(7'h43, {2'b00, OP_READ, REG_ADDR_MEAS, 16'h0000}, 4, 1'b1);
    check(rd, 16'h8000, "first conversion");
    $display("test address table done");
  endtask : t_codes
  task t_override();
    xfer(7'h43, {2'b00, OP_WRITE, REG_ADDR_OVR, 16'h8055}, 4, 1'b0);
    probe(7'h51, 1'b1, "override i2c");
    probe(7'h55, 1'b1, "override pmbus");
    probe(7'h43, 1'b0, "old address");
    xfer(7'h51, {2'b00, OP_READ, REG_ADDR_OVR, 16'h0000}, 4, 1'b1);
    check(rd, 16'h8055, "override readback");
    cfg_done = 1'b0;
    probe(7'h43, 1'b1, "table before configuration");
    probe(7'h51, 1'b0, "override before configuration");
    cfg_done = 1'b1;
    $display("test override done");
  endtask : t_override
  task t_pmbus();
    logic [7:0] pg [10] = '{8'h01, 8'h02, 8'h06, 8'h0D, 8'h0E, 8'h0F, 8'h20, 8'h21, 8'h22,
      8'h23};
    for (int i = 0; i < 10; i++) begin
      xfer(7'h55, {16'h0000, pg[i], PM_PAGE}, 2, 1'b0);
      check({10'h000, sense_chan}, {10'h000, pg[i][5:0]}, "page channel");
    end
    xfer(7'h55, {24'h00_0000, PM_READ_VOUT}, 1, 1'b1);
    check(rd, 16'h3EA7, "voltage");
    xfer(7'h55, {24'h00_0000, PM_VOUT_MODE}, 1, 1'b1);
    check({8'h00, rd[7:0]}, 16'h0012, "mode byte");
    xfer(7'h55, {24'h00_0000, PM_READ_TEMP}, 1, 1'b1);
    check(rd, 16'hEA81, "temperature");
    xfer(7'h55, {24'h00_0000, PM_RAW_SUPPLY}, 1, 1'b1);
    check(rd, 16'h538A, "raw code");
    xfer(7'h55, {16'h0000, PAGE_ALL, PM_PAGE}, 2, 1'b0);
    fc_seen = 1'b0;
    fa_seen = 1'b0;
    xfer(7'h55, {24'h00_0000, PM_CLEAR_FAULT}, 1, 1'b0);
    check({14'h0000, fc_seen, fa_seen}, 16'h0003, "clear all");
    xfer(7'h55, {16'h0000, 8'h01, PM_PAGE}, 2, 1'b0);
    fc_seen = 1'b0;
    fa_seen = 1'b0;
    xfer(7'h55, {24'h00_0000, PM_CLEAR_FAULT}, 1, 1'b0);
    check({14'h0000, fc_seen, fa_seen}, 16'h0002, "clear one");
    $display("test pmbus done");
  endtask : t_pmbus
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    nrst = 1'b0;
    cfg_done = 1'b0;
    adc_eoc = 1'b0;
    adc_data = 16'h0000;
    supply_code = 16'h538A;
    temp_mant = 11'h281;
    temp_exp = 5'h1D;
    errors = 0;
    check_count = 0;
    cycles = 0;
    t_reset();
    t_codes();
    t_override();
    t_pmbus();
    end_of_test();
  end
endmodule : tb_monitor_i2c_pmbus_slave_access
